// *** dv/gpc_general_pin_config_props.sv ***
// Checker for the general configuration block
`timescale 1ns/100ps
`default_nettype none
module gpc_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	input wire logic [10:0] out_func,
	input wire logic [31:0] gpo_val,
	input wire logic [10:0] out_pin,
	input wire logic primary_disk_oe,
	input wire logic secondary_disk_oe,
	input wire logic io_cycle,
	input wire logic [15:0] io_addr,
	input wire logic pnp_forward
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic hit;
	// Register address match
	assign hit = cfg_addr[7:2] == 6'h2C;
	AST_KBC_MUX: assert property (cfg_wr && hit && cfg_be[3] |=>
		out_pin[10] == ($past(cfg_wdata[31]) ? gpo_val[26] : out_func[10])) else $error("kbd select mux wrong");
	AST_XBUS_MUX: assert property (cfg_wr && hit && cfg_be[3] |=>
		out_pin[7] == ($past(cfg_wdata[28]) ? gpo_val[23] : out_func[7])) else $error("xbus mux wrong");
	AST_SUS_MUX: assert property (cfg_wr && hit && cfg_be[2] |=>
		out_pin[5] == ($past(cfg_wdata[22]) ? gpo_val[21] : out_func[5])) else $error("suspend mux wrong");
	AST_HALT_MUX: assert property (cfg_wr && hit && cfg_be[2] |=>
		out_pin[1] == ($past(cfg_wdata[18]) ? gpo_val[17] : out_func[1])) else $error("halt mux wrong");
	AST_SLEEP_MUX: assert property (cfg_wr && hit && cfg_be[2] |=>
		out_pin[0] == ($past(cfg_wdata[17]) ? gpo_val[15] : out_func[0])) else $error("sleep mux wrong");
	AST_PRI_TRI: assert property (cfg_wr && hit && cfg_be[1] |=>
		primary_disk_oe == !$past(cfg_wdata[11])) else $error("primary enable wrong");
	AST_SEC_TRI: assert property (cfg_wr && hit && cfg_be[1] |=>
		secondary_disk_oe == !$past(cfg_wdata[12])) else $error("secondary enable wrong");
	AST_PNP_ADDR: assert property (pnp_forward |-> io_cycle &&
		(io_addr == 16'h0279 || io_addr == 16'h0A79)) else $error("pnp forward on wrong cycle");
	AST_RSVD_ZERO: assert property (cfg_rd && hit |=>
		!cfg_rdata[26] && !cfg_rdata[13] && !cfg_rdata[7]) else $error("reserved bit reads one");
	AST_UNMAP_ZERO: assert property (cfg_rd && !hit |=> cfg_rdata == 32'h00000000)
		else $error("unmapped read not zero");
	COV_WRITE: cover property (cfg_wr && hit && cfg_be == 4'hF);
	COV_PNP: cover property (pnp_forward);
	COV_UNMAP: cover property (cfg_rd && !hit);
endmodule : gpc_props
bind gpc_general_pin_config gpc_props u_gpc_props (.clk, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
	.cfg_wdata, .cfg_rdata, .out_func, .gpo_val, .out_pin, .primary_disk_oe, .secondary_disk_oe,
	.io_cycle, .io_addr, .pnp_forward);
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the general configuration block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk, rst, cfg_wr, cfg_rd, spare_strap, cpu_family_strap, channel_check_input, io_cycle;
	logic processor_soft_restart_req, processor_hard_reset_req, cfg_hit, channel_check_func;
	logic processor_soft_restart, processor_hard_reset, primary_disk_oe, secondary_disk_oe;
	logic disk_drive_split, pnp_forward, positive_decode, alt_access_mode, full_expansion_bus;
	logic sleep_control_c;
	logic [7:0] cfg_addr;
	logic [3:0] cfg_be;
	logic [31:0] cfg_wdata, gpo_val, cfg_rdata;
	logic [10:0] out_func, out_pin;
	logic [6:0] in_pin, in_func, upper_latched_address_func, upper_latched_address;
	logic [12:0] gpi_val;
	logic [2:0] dma_req_pin, dma_gnt_pin, dma_gnt_func, dma_req_func;
	logic [15:0] io_addr;
	int n_fail = 0;
	int checks_done = 0;
	int cyc = 0;
	localparam int GI [11] = '{15, 17, 18, 19, 20, 21, 22, 23, 24, 25, 26};
	localparam int SB [11] = '{17, 18, 19, 20, 21, 22, 28, 28, 29, 30, 31};
	gpc_general_pin_config u_gpc_general_pin_config (.clk, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
		.cfg_wdata, .cfg_rdata, .cfg_hit, .spare_strap, .cpu_family_strap, .out_func, .gpo_val, .out_pin,
		.sleep_control_c,
		.in_pin, .in_func, .gpi_val, .dma_req_pin, .dma_gnt_pin, .dma_gnt_func, .dma_req_func,
		.channel_check_input, .channel_check_func, .upper_latched_address_func, .upper_latched_address,
		.processor_soft_restart_req, .processor_hard_reset_req, .processor_soft_restart,
		.processor_hard_reset, .primary_disk_oe, .secondary_disk_oe, .disk_drive_split, .io_cycle,
		.io_addr, .pnp_forward, .positive_decode, .alt_access_mode, .full_expansion_bus);
	// Clock of 50 ns
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run
	// Hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_fail++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [31:0] d, input logic [3:0] be);
		@(posedge clk);
		cfg_wr <= 1'b1;
		cfg_wdata <= d;
		cfg_be <= be;
		@(posedge clk);
		cfg_wr <= 1'b0;
		@(negedge clk);
	endtask : wr
	task automatic rd;
		@(posedge clk);
		cfg_rd <= 1'b1;
		@(posedge clk);
		cfg_rd <= 1'b0;
		@(negedge clk);
	endtask : rd
	function automatic logic [10:0] exp_out(input logic [31:0] r);
		logic [10:0] e;
		for (int i = 0; i < 11; i++)
			e[i] = r[SB[i]] ? gpo_val[GI[i]] : out_func[i];
		return e;
	endfunction : exp_out
	task automatic t_reset;
		rd();
		chk(cfg_rdata, 32'h00000004);
		chk(out_pin, out_func);
		chk({primary_disk_oe, secondary_disk_oe}, 2'b11);
		chk(gpi_val, 13'h0015);
		chk(in_func, 7'h2F);
		chk({dma_gnt_pin, dma_req_func}, {gpo_val[11:9], 3'b111});
		chk(upper_latched_address, gpo_val[7:1]);
		chk({processor_soft_restart, processor_hard_reset}, 2'b10);
		chk(sleep_control_c, out_func[0]);
		chk(cfg_hit, 1'b1);
		$display("test reset done");
	endtask : t_reset
	task automatic t_all;
		wr(32'hFFFFFFFF, 4'hF);
		chk(out_pin, exp_out(32'hFFFFFFFF));
		rd();
		chk(cfg_rdata, 32'hFBFFDF77);
		chk({primary_disk_oe, secondary_disk_oe}, 2'b00);
		chk({disk_drive_split, alt_access_mode, positive_decode, full_expansion_bus}, 4'hF);
		chk(gpi_val, 13'h0D00);
		chk(in_func, 7'h7A);
		chk({dma_gnt_pin, dma_req_func}, {dma_gnt_func, dma_req_pin});
		chk(upper_latched_address, upper_latched_address_func);
		chk(channel_check_func, channel_check_input);
		chk(sleep_control_c, gpo_val[16]);
		$display("test all ones done");
	endtask : t_all
	task automatic t_lane;
		wr(32'h00000000, 4'hF);
		wr(32'hFFFFFFFF, 4'h2);
		chk(out_pin, out_func);
		chk({primary_disk_oe, secondary_disk_oe}, 2'b00);
		rd();
		chk(cfg_rdata, 32'h0000DF04);
		$display("test lane done");
	endtask : t_lane
	task automatic t_pnp;
		// Positive decode chosen together with the pnp enable
		wr(32'h00000042, 4'h1);
		foreach (GI[i])
		begin
			@(posedge clk);
			io_addr <= i[0] ? 16'h0279 : 16'h0A79 - 16'(i[1]);
			io_cycle <= i < 9;
			@(negedge clk);
			chk(pnp_forward, (i[0] || !i[1]) && i < 9);
		end
		wr(32'h00000000, 4'h1);
		@(posedge clk);
		io_addr <= 16'h0279;
		io_cycle <= 1'b1;
		@(negedge clk);
		chk(pnp_forward, 1'b0);
		$display("test pnp done");
	endtask : t_pnp
	task automatic t_unmap;
		@(posedge clk);
		io_cycle <= 1'b0;
		cfg_addr <= 8'hB4;
		wr(32'hFFFFFFFF, 4'hF);
		rd();
		chk(cfg_rdata, 32'h00000000);
		@(posedge clk);
		cfg_addr <= 8'hB0;
		rd();
		chk(cfg_rdata, 32'h0000DF04);
		$display("test unmapped done");
	endtask : t_unmap
	// Stimulus
	initial
	begin
		{rst, cfg_wr, cfg_rd, spare_strap, io_cycle, processor_soft_restart_req} = 6'b100000;
		{cpu_family_strap, channel_check_input, processor_hard_reset_req} = 3'b111;
		{cfg_addr, cfg_be, cfg_wdata, io_addr} = {8'hB0, 4'h0, 32'h0, 16'h0};
		{gpo_val, out_func, in_pin} = {32'h0AA53C96, 11'h5A3, 7'h2A};
		{upper_latched_address_func, dma_req_pin, dma_gnt_func} = {7'h35, 3'h5, 3'h2};
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_all();
		t_lane();
		t_pnp();
		t_unmap();
		complete_run();
	end
endmodule : tb_top
`default_nettype wire

// *** hdl/gpc_cfg.svh ***
// Offsets, field positions and reset values of the general configuration register
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH
`define GPC_CFG_OFFSET 8'hB0
`define GPC_RESET_VALUE 32'h00000000
`define GPC_WRITE_MASK 32'hFBFFDF73
`define GPC_RO_MASK 32'h0000000C
`define GPC_BIT_KBC 31
`define GPC_BIT_RTCL 30
`define GPC_BIT_RTCS 29
`define GPC_BIT_XBUS 28
`define GPC_BIT_MODEM 27
`define GPC_BIT_COVER 25
`define GPC_BIT_BATT 24
`define GPC_BIT_THERM 23
`define GPC_BIT_SUS2 22
`define GPC_BIT_SUS1 21
`define GPC_BIT_CSLP 20
`define GPC_BIT_BHALT 19
`define GPC_BIT_PHALT 18
`define GPC_BIT_SLEEP 17
`define GPC_BIT_SERIAL_INTERRUPT_LINE 16
`define GPC_BIT_ALERT 15
`define GPC_BIT_ALARM 14
`define GPC_BIT_SEC_TRI 12
`define GPC_BIT_PRI_TRI 11
`define GPC_BIT_DMA_C 10
`define GPC_BIT_DMA_B 9
`define GPC_BIT_DMA_A 8
`define GPC_BIT_PNP 6
`define GPC_BIT_ALT 5
`define GPC_BIT_SPLIT 4
`define GPC_BIT_SPARE 3
`define GPC_BIT_CPU 2
`define GPC_BIT_DECODE 1
`define GPC_BIT_BUS 0
`define GPC_PNP_ADDR_LO 16'h0279
`define GPC_PNP_ADDR_HI 16'h0A79
`endif

// *** hdl/gpc_general_pin_config.sv ***
// General configuration register with its pin-function multiplexers
//
// Summary of operation
// - Bits 31..29 set route three select pins to gpo 26, 25, 24.
// - Bit 28 set turns xbus enable and direction pins into gpo 23, 22.
// - Bits 27, 25 set make modem wake and cover pins gpi 12, 10.
// - Bits 24, 23 set make low battery and thermal pins gpi 9, 8.
// - Bits 22, 21 set make suspend state pins gpo 21, 20.
// - Bits 20..18 set make sleep and clock halt pins gpo 19, 18, 17.
// - Bit 17 set makes sleep control b and c pins gpo 15, 16.
// - Bit 16 clear makes serial interrupt pin gpi 7; set gives serial interrupt.
// - Bit 15 set makes the alert pin gpi 11; clear keeps alert.
// - Bit 14 clear makes clock alarm pin gpi 6; set gives alarm input.
// - Bit 12 set tri-states all secondary disk pins, independent of bit 4.
// - Bit 11 set tri-states all primary disk pins, independent of bit 4.
// - Bits 10..8 set give dma pairs c, b, a; clear gives gpi and gpo.
// - Bit 6 set positively decodes and forwards io 279h and A79h.
// - Bit 5 set enables alternate access mode for shadow register reads.
// - Bit 4 selects primary/secondary split or drive 0/drive 1 split.
// - Bit 3 reads the spare strap pin; board pulls it low.
// - Bit 2 reads cpu family strap; it inverts restart and reset polarity.
// - Bit 1 clear selects subtractive decode, set selects positive decode.
// - Bit 0 clear selects extended io bus with gpi 0 and gpo 1..7.
`timescale 1ns/100ps
`default_nettype none
`include "gpc_cfg.svh"
module gpc_general_pin_config (
	input wire logic clk,
	input wire logic rst,
	// Configuration access port
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_hit,
	// Strap pins
	input wire logic spare_strap,
	input wire logic cpu_family_strap,
	// Dedicated output functions and general-purpose output values
	input wire logic [10:0] out_func,
	input wire logic [31:0] gpo_val,
	output logic [10:0] out_pin,
	output logic sleep_control_c,
	// Dedicated input pins: modem, cover, battery, thermal, serial_interrupt_line, alert, alarm
	input wire logic [6:0] in_pin,
	output logic [6:0] in_func,
	output logic [12:0] gpi_val,
	// Dma request/grant pins c, b, a
	input wire logic [2:0] dma_req_pin,
	output logic [2:0] dma_gnt_pin,
	input wire logic [2:0] dma_gnt_func,
	output logic [2:0] dma_req_func,
	// Expansion bus shared pins
	input wire logic channel_check_input,
	output logic channel_check_func,
	input wire logic [6:0] upper_latched_address_func,
	output logic [6:0] upper_latched_address,
	// Processor control polarity
	input wire logic processor_soft_restart_req,
	input wire logic processor_hard_reset_req,
	output logic processor_soft_restart,
	output logic processor_hard_reset,
	// Disk interface enables and configuration
	output logic primary_disk_oe,
	output logic secondary_disk_oe,
	output logic disk_drive_split,
	// Decode control
	input wire logic io_cycle,
	input wire logic [15:0] io_addr,
	output logic pnp_forward,
	output logic positive_decode,
	output logic alt_access_mode,
	output logic full_expansion_bus
);
	logic [31:0] cfg_ff;
	logic [31:0] nxt_cfg;
	logic [31:0] be_mask;
	logic [1:0] strap_ff;
	logic [31:0] read_word;
	logic [31:0] rdata_ff;
	logic [10:0] out_sel;
	logic [6:0] in_gpi_sel;
	logic [6:0] in_gpi;
	logic [6:0] in_idle;
	logic [6:0] func_raw;
	logic [2:0] dma_en;
	logic cpu_second_gen;
	gpc_pkg::gpc_decode_t decode_mode;
	gpc_pkg::gpc_bus_t bus_mode;

	// Address match for the one register
	assign cfg_hit = (cfg_addr[7:2] == 6'(`GPC_CFG_OFFSET >> 2));
	assign be_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};

	// Byte-enabled write merge of the writable bits
	always_comb
	begin
		nxt_cfg = cfg_ff;
		if (cfg_wr && cfg_hit)
		begin
			nxt_cfg = ((cfg_ff & ~be_mask) | (cfg_wdata & be_mask)) & `GPC_WRITE_MASK;
		end
	end

	// Register storage, cleared by system reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cfg_ff <= `GPC_RESET_VALUE;
		else
			cfg_ff <= nxt_cfg;
	end

	// Strap sampling every cycle, constant under reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			strap_ff <= 2'h0;
		else
			strap_ff <= {spare_strap, cpu_family_strap};
	end

	// Read word assembly with strap status bits
	always_comb
	begin
		read_word = cfg_ff & `GPC_WRITE_MASK;
		read_word[`GPC_BIT_SPARE] = strap_ff[1];
		read_word[`GPC_BIT_CPU] = strap_ff[0];
	end

	// Registered read data
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata_ff <= 32'h00000000;
		else if (cfg_rd && cfg_hit)
			rdata_ff <= read_word;
		else if (cfg_rd)
			rdata_ff <= 32'h00000000; // Unmapped reads return zero
	end
	assign cfg_rdata = rdata_ff;

	// Output pin selects, bit order: kbc, rtcl, rtcs, xoe, xbus_direction, sus2, sus1, cslp, bhalt, phalt, slpb
	always_comb
	begin
		out_sel = 11'h000;
		out_sel[10] = cfg_ff[`GPC_BIT_KBC];
		out_sel[9] = cfg_ff[`GPC_BIT_RTCL];
		out_sel[8] = cfg_ff[`GPC_BIT_RTCS];
		out_sel[7] = cfg_ff[`GPC_BIT_XBUS];
		out_sel[6] = cfg_ff[`GPC_BIT_XBUS];
		out_sel[5] = cfg_ff[`GPC_BIT_SUS2];
		out_sel[4] = cfg_ff[`GPC_BIT_SUS1];
		out_sel[3] = cfg_ff[`GPC_BIT_CSLP];
		out_sel[2] = cfg_ff[`GPC_BIT_BHALT];
		out_sel[1] = cfg_ff[`GPC_BIT_PHALT];
		out_sel[0] = cfg_ff[`GPC_BIT_SLEEP];
	end

	// Output pin multiplexers; sleep control c is handled below with slpb
	gpc_pin_mux #(
		.WIDTH(11)
	) u_out_mux (
		.sel(out_sel),
		.func_val(out_func),
		.gpo_val({gpo_val[26], gpo_val[25], gpo_val[24], gpo_val[23], gpo_val[22], gpo_val[21],
			gpo_val[20], gpo_val[19], gpo_val[18], gpo_val[17], gpo_val[15]}),
		.pin_val(out_pin)
	);

	// Input selects, bit order: modem, cover, batt, therm, serial_interrupt_line, alert, alarm
	always_comb
	begin
		in_gpi_sel[6] = cfg_ff[`GPC_BIT_MODEM];
		in_gpi_sel[5] = cfg_ff[`GPC_BIT_COVER];
		in_gpi_sel[4] = cfg_ff[`GPC_BIT_BATT];
		in_gpi_sel[3] = cfg_ff[`GPC_BIT_THERM];
		in_gpi_sel[2] = ~cfg_ff[`GPC_BIT_SERIAL_INTERRUPT_LINE];
		in_gpi_sel[1] = cfg_ff[`GPC_BIT_ALERT];
		in_gpi_sel[0] = ~cfg_ff[`GPC_BIT_ALARM];
	end

	// Active-low inputs idle high, serial interrupt line idles high too
	assign in_idle = 7'h7F;

	gpc_in_demux #(
		.WIDTH(7)
	) u_in_demux (
		.gpi_sel(in_gpi_sel),
		.pin_val(in_pin),
		.idle_val(in_idle),
		.func_val(func_raw),
		.gpi_val(in_gpi)
	);
	assign in_func = func_raw;

	assign dma_en = {cfg_ff[`GPC_BIT_DMA_C], cfg_ff[`GPC_BIT_DMA_B], cfg_ff[`GPC_BIT_DMA_A]};

	// Dma request inputs: function or gpi 4, 3, 2; grant outputs: function or gpo 11, 10, 9
	gpc_pin_mux #(
		.WIDTH(3)
	) u_gnt_mux (
		.sel(~dma_en),
		.func_val(dma_gnt_func),
		.gpo_val({gpo_val[11], gpo_val[10], gpo_val[9]}),
		.pin_val(dma_gnt_pin)
	);
	assign dma_req_func = dma_en & dma_req_pin | ~dma_en;

	assign bus_mode = gpc_pkg::gpc_bus_t'(cfg_ff[`GPC_BIT_BUS]);
	assign full_expansion_bus = (bus_mode == gpc_pkg::GPC_BUS_FULL);
	assign channel_check_func = full_expansion_bus ? channel_check_input : 1'b1;
	assign upper_latched_address = full_expansion_bus ? upper_latched_address_func : gpo_val[7:1];

	// General-purpose input collection
	always_comb
	begin
		gpi_val = 13'h0000;
		gpi_val[12] = in_gpi[6];
		gpi_val[10] = in_gpi[5];
		gpi_val[9] = in_gpi[4];
		gpi_val[8] = in_gpi[3];
		gpi_val[7] = in_gpi[2];
		gpi_val[11] = in_gpi[1];
		gpi_val[6] = in_gpi[0];
		gpi_val[4:2] = ~dma_en & dma_req_pin;
		// Gpi 0 on channel check pin
		gpi_val[0] = ~full_expansion_bus & channel_check_input;
	end

	// Sleep control c follows same select
	logic sleep_c_pin;
	assign sleep_c_pin = cfg_ff[`GPC_BIT_SLEEP] ? gpo_val[16] : out_func[0];

	assign cpu_second_gen = strap_ff[0];
	assign processor_soft_restart = processor_soft_restart_req ^ cpu_second_gen;
	assign processor_hard_reset = processor_hard_reset_req ^ cpu_second_gen;

	assign primary_disk_oe = ~cfg_ff[`GPC_BIT_PRI_TRI];
	assign secondary_disk_oe = ~cfg_ff[`GPC_BIT_SEC_TRI];
	assign disk_drive_split = cfg_ff[`GPC_BIT_SPLIT];
	assign alt_access_mode = cfg_ff[`GPC_BIT_ALT];

	assign decode_mode = gpc_pkg::gpc_decode_t'(cfg_ff[`GPC_BIT_DECODE]);
	assign positive_decode = (decode_mode == gpc_pkg::GPC_DECODE_POSITIVE);

	assign pnp_forward = io_cycle && cfg_ff[`GPC_BIT_PNP] &&
		((io_addr == `GPC_PNP_ADDR_LO) || (io_addr == `GPC_PNP_ADDR_HI));

	// Second sleep control pin goes out through its own sleep_control_c port
	assign sleep_control_c = sleep_c_pin;
endmodule : gpc_general_pin_config
`default_nettype wire

// *** hdl/gpc_in_demux.sv ***
// Per-pin steering of an input pin to its dedicated function or a general-purpose input
`timescale 1ns/100ps
`default_nettype none
module gpc_in_demux #(
	parameter int WIDTH = 1
) (
	input wire logic [WIDTH-1:0] gpi_sel,
	input wire logic [WIDTH-1:0] pin_val,
	input wire logic [WIDTH-1:0] idle_val,
	output logic [WIDTH-1:0] func_val,
	output logic [WIDTH-1:0] gpi_val
);
	genvar i;
	// Unselected side sees its idle level, gpi side reads zero
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_demux
			assign func_val[i] = gpi_sel[i] ? idle_val[i] : pin_val[i];
			assign gpi_val[i] = gpi_sel[i] ? pin_val[i] : 1'b0;
		end
	endgenerate
endmodule : gpc_in_demux
`default_nettype wire

// *** hdl/gpc_pin_mux.sv ***
// Per-pin selector between a dedicated output function and a general-purpose output
`timescale 1ns/100ps
`default_nettype none
module gpc_pin_mux #(
	parameter int WIDTH = 1
) (
	input wire logic [WIDTH-1:0] sel,
	input wire logic [WIDTH-1:0] func_val,
	input wire logic [WIDTH-1:0] gpo_val,
	output logic [WIDTH-1:0] pin_val
);
	genvar i;
	// One selector per pin, set selects the general-purpose output
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_mux
			assign pin_val[i] = sel[i] ? gpo_val[i] : func_val[i];
		end
	endgenerate
endmodule : gpc_pin_mux
`default_nettype wire

// *** hdl/gpc_pkg.sv ***
// Types shared by the general configuration block
package gpc_pkg;
	typedef enum logic [0:0] {
		GPC_DECODE_SUBTRACTIVE = 1'b0,
		GPC_DECODE_POSITIVE = 1'b1
	} gpc_decode_t;
	typedef enum logic [0:0] {
		GPC_BUS_EXTENDED = 1'b0,
		GPC_BUS_FULL = 1'b1
	} gpc_bus_t;
endpackage : gpc_pkg
